//--- src/scr_regs.sv
// Purpose: SDRAM controller configuration, check-code path and error report
// Assumes: All inputs synchronous to i_clk; register strobes one cycle each
// Notes: Refresh, command and timing engines sit outside this block
// Function
// - Timing bit 12 adds one extra read sampling stage.
// - Timing bit 13 turns check-code checking on; generation runs regardless.
// - Bit 14 picks one or two read stages; check codes force two.
// - As slave, promote pending request after nonzero escalation count cycles.
// - As slave, release bus after release count; zero releases when idle.
// - Bit 16 enables shared arbitration; software maps request/grant pins.
// - Bit 17 picks master or slave; both bits load at reset.
// - Sixteen 4-bit slices served in turn, each naming a requester.
// - Arbiter timer preset 0xff; bit 16 set disables, reset disabled.
// - Bank density code: 1,2,3 legal, 0 reserved, reset 3.
// - Per-bank page bit: zero closes page, one keeps it open.
// - Capture first error only; rearm after error address read.
// - Capture failing 64-bit word into low and high registers.
// - Error kind: 00 none, 01 corrected, 10 multiple.
// - Failing address goes into bits 31:2 of error address.
// - Errors raise interrupt unless masked; writing zero kind clears.
// - Record received and computed check bytes of captured error.
// - Control bit 8 writes software check byte instead of computed.
// - Control bit 9 with parity error writes uncorrectable check byte.
// - Threshold counts single errors before interrupt; zero suppresses.
// - 32-bit single-error counter wraps to zero.
// - Check byte is XOR of codes of all set data bits.
// - Single data-bit errors are corrected on delivery.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module scr_regs (
   input wire logic i_clk, // Core clock, 200 MHz
   input wire logic i_rstn, // Synchronous reset, active low
   input wire logic i_shm_enable_strap, // Reset value of enable bit
   input wire logic i_shm_role_strap, // Reset value of role bit
   input wire logic [11:0] i_addr, // Register byte address
   input wire logic [31:0] i_wdata, // Register write data
   input wire logic i_wr, // Write strobe
   input wire logic i_rd, // Read strobe
   output logic [31:0] o_rdata, // Read data, cycle after i_rd
   input wire logic [63:0] i_wr_data, // Write data toward SDRAM
   input wire logic i_wr_parity_err, // Originating parity error flag
   output logic [7:0] o_wr_check, // Check byte to write
   input wire logic i_rd_valid, // Read beat valid
   input wire logic [63:0] i_rd_data, // Raw read data
   input wire logic [7:0] i_rd_check, // Raw read check byte
   input wire logic [31:0] i_rd_addr, // Address of read beat
   output logic o_rd_valid, // Delivered beat valid
   output logic [63:0] o_rd_data, // Delivered (corrected) data
   input wire logic i_irq_mask, // Masks error interrupt
   output logic o_irq, // Error interrupt level
   input wire logic i_int_pending, // Internal SDRAM request pending
   input wire logic i_high_prio, // Internal request is urgent
   input wire logic i_grant_n, // Shared bus grant, active low
   output logic o_request_n, // Shared bus request, active low
   output logic o_high_prio_req, // Request promoted to high priority
   input wire logic [4:0] i_xbar_req, // Requesters: cpu,pci,comm,dma bits 0..3
   output logic [3:0] o_xbar_owner, // Slice code now served
   output logic o_xbar_timeout, // Arbiter timer expired
   output logic [1:0] o_density [4], // Density code per bank
   output logic [3:0] o_keep_page [4], // Page policy per bank
   output logic [1:0] o_read_stages // Read stages in use, 1..3
);
   typedef enum logic [1:0] {SHM_IDLE, SHM_WAIT, SHM_OWN, SHM_GAP} scr_shm_t;
   typedef struct packed {
      logic [31:0] timing, shm, xlo, xhi, xto, ctrl, cnt;
      logic [31:0] bank0, bank1, bank2, bank3;
      logic [63:0] edata;
      logic [7:0] erx, ecalc;
      logic [31:0] eaddr;
      logic armed;
      logic [7:0] thr_cnt;
      logic irq;
      logic [31:0] rdata;
      logic [3:0] slice;
      logic [7:0] tmr;
      logic tout;
      scr_shm_t shm_st;
      logic [7:0] shm_cnt;
      logic [1:0] gap;
      logic hp;
      logic [63:0] p1, p2, p3;
      logic [2:0] v;
      logic [63:0] od;
      logic ov;
   } scr_state_t;
   scr_state_t s_r, s_nxt;

   // Check code of a 64-bit word
   function automatic logic [7:0] code_of(input logic [63:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 64; i++) begin
         if (d[i]) begin
            c = c ^ scr_pkg::CODE_TABLE[8*i +: 8];
         end
      end
      return c;
   endfunction

   function automatic logic [31:0] bank_rd(input logic [31:0] v);
      return v & scr_pkg::MASK_BANK;
   endfunction

   logic ecc_on;
   logic [7:0] calc, syn;
   logic [3:0] ones;
   logic [63:0] fixed;
   logic single, multi;
   logic [3:0] code_now;
   logic slice_req;

   assign ecc_on = s_r.timing[scr_pkg::TIM_ECC_BIT];
   assign calc = code_of(i_rd_data);
   assign syn = ecc_on ? (calc ^ i_rd_check) : 8'h00;
   assign ones = 4'($countones(syn));

   always_comb begin
      fixed = i_rd_data;
      single = 1'b0;
      multi = 1'b0;
      if (ones == 4'h3 || ones == 4'h5) begin
         for (int i = 0; i < 64; i++) begin
            if (scr_pkg::CODE_TABLE[8*i +: 8] == syn) begin
               fixed[i] = ~i_rd_data[i];
               single = 1'b1;
            end
         end
      end
      // Odd syndromes matching no data bit are uncorrectable; single check-bit flips are ignored
      if (ones > 4'h1 && !single) begin
         multi = 1'b1;
      end
   end

   // Write path check byte
   always_comb begin
      if (s_r.ctrl[scr_pkg::CTL_OVERRIDE_BIT]) begin
         o_wr_check = s_r.ctrl[7:0];
      end else if (s_r.ctrl[scr_pkg::CTL_PROP_BIT] && i_wr_parity_err) begin
         o_wr_check = code_of(i_wr_data) ^ 8'h03;
      end else begin
         o_wr_check = code_of(i_wr_data);
      end
   end

   always_comb begin
      code_now = s_r.slice[3] ? s_r.xhi[{s_r.slice[2:0], 2'b00} +: 4]
                              : s_r.xlo[{s_r.slice[2:0], 2'b00} +: 4];
      unique case (code_now)
         scr_pkg::SLICE_CPU: slice_req = i_xbar_req[0];
         scr_pkg::SLICE_PCI: slice_req = i_xbar_req[1];
         scr_pkg::SLICE_COMM: slice_req = i_xbar_req[2];
         scr_pkg::SLICE_DMA: slice_req = i_xbar_req[3];
         default: slice_req = 1'b0; // Null and reserved codes pass at once
      endcase
   end

   // ==========================================================
   // State update
   always_comb begin
      s_nxt = s_r;
      s_nxt.rdata = 32'h0;
      // Register writes
      if (i_wr) begin
         unique case (i_addr)
            scr_pkg::OFF_BANK0: s_nxt.bank0 = i_wdata & scr_pkg::MASK_BANK;
            scr_pkg::OFF_BANK1: s_nxt.bank1 = i_wdata & scr_pkg::MASK_BANK;
            scr_pkg::OFF_BANK2: s_nxt.bank2 = i_wdata & scr_pkg::MASK_BANK;
            scr_pkg::OFF_BANK3: s_nxt.bank3 = i_wdata & scr_pkg::MASK_BANK;
            scr_pkg::OFF_ECC_CTRL: s_nxt.ctrl = i_wdata & scr_pkg::MASK_CTRL;
            scr_pkg::OFF_SHM_CTRL: s_nxt.shm = i_wdata & scr_pkg::MASK_SHM;
            scr_pkg::OFF_XBAR_LO: s_nxt.xlo = i_wdata;
            scr_pkg::OFF_XBAR_HI: s_nxt.xhi = i_wdata;
            scr_pkg::OFF_XBAR_TO: s_nxt.xto = i_wdata & scr_pkg::MASK_TO;
            scr_pkg::OFF_TIMING: s_nxt.timing = i_wdata & scr_pkg::MASK_TIMING;
            scr_pkg::OFF_ERR_ADDR: begin
               if (i_wdata[1:0] == scr_pkg::ERR_NONE) begin
                  s_nxt.irq = 1'b0;
                  s_nxt.eaddr[1:0] = scr_pkg::ERR_NONE;
               end
            end
            default: ;
         endcase
      end
      // Register reads
      if (i_rd) begin
         unique case (i_addr)
            scr_pkg::OFF_BANK0: s_nxt.rdata = bank_rd(s_r.bank0);
            scr_pkg::OFF_BANK1: s_nxt.rdata = bank_rd(s_r.bank1);
            scr_pkg::OFF_BANK2: s_nxt.rdata = bank_rd(s_r.bank2);
            scr_pkg::OFF_BANK3: s_nxt.rdata = bank_rd(s_r.bank3);
            scr_pkg::OFF_ERR_HI: s_nxt.rdata = s_r.edata[63:32];
            scr_pkg::OFF_ERR_LO: s_nxt.rdata = s_r.edata[31:0];
            scr_pkg::OFF_RX_ECC: s_nxt.rdata = {24'h0, s_r.erx};
            scr_pkg::OFF_CALC_ECC: s_nxt.rdata = {24'h0, s_r.ecalc};
            scr_pkg::OFF_ERR_ADDR: begin
               s_nxt.rdata = s_r.eaddr;
               s_nxt.armed = 1'b1;
            end
            scr_pkg::OFF_ECC_CTRL: s_nxt.rdata = s_r.ctrl;
            scr_pkg::OFF_ECC_CNT: s_nxt.rdata = s_r.cnt;
            scr_pkg::OFF_SHM_CTRL: s_nxt.rdata = s_r.shm;
            scr_pkg::OFF_XBAR_LO: s_nxt.rdata = s_r.xlo;
            scr_pkg::OFF_XBAR_HI: s_nxt.rdata = s_r.xhi;
            scr_pkg::OFF_XBAR_TO: s_nxt.rdata = s_r.xto;
            scr_pkg::OFF_TIMING: s_nxt.rdata = s_r.timing;
            default: s_nxt.rdata = 32'h0; // Unmapped reads return zero
         endcase
      end
      // Error capture; a multiple error, or a single error reaching the threshold, re-sets irq over a same-cycle clear
      if (i_rd_valid && (single || multi)) begin
         if (s_r.armed) begin
            s_nxt.armed = 1'b0;
            s_nxt.edata = i_rd_data;
            s_nxt.erx = i_rd_check;
            s_nxt.ecalc = calc;
            s_nxt.eaddr = {i_rd_addr[31:2], single ? scr_pkg::ERR_SINGLE
                                                    : scr_pkg::ERR_MULTI};
         end
         if (multi) begin
            s_nxt.irq = 1'b1;
         end
      end
      if (i_rd_valid && single) begin
         s_nxt.cnt = s_r.cnt + 32'h1;
         if (s_r.ctrl[23:16] != 8'h00) begin
            if (s_r.thr_cnt + 8'h1 >= s_r.ctrl[23:16]) begin
               s_nxt.irq = 1'b1;
               s_nxt.thr_cnt = 8'h00;
            end else begin
               s_nxt.thr_cnt = s_r.thr_cnt + 8'h1;
            end
         end
      end
      // Read path pipeline
      s_nxt.p1 = fixed;
      s_nxt.p2 = s_r.p1;
      s_nxt.p3 = s_r.p2;
      s_nxt.v = {s_r.v[1:0], i_rd_valid};
      s_nxt.od = (o_read_stages == 2'd1) ? s_r.p1 :
                 (o_read_stages == 2'd2) ? s_r.p2 : s_r.p3;
      s_nxt.ov = s_r.v[o_read_stages - 2'd1];
      // Crossbar pizza arbiter with timer
      if (!slice_req || s_r.tout) begin
         s_nxt.slice = s_r.slice + 4'h1;
         s_nxt.tmr = s_r.xto[7:0];
         s_nxt.tout = 1'b0;
      end else if (!s_r.xto[scr_pkg::TO_DISABLE_BIT]) begin
         if (s_r.tmr == 8'h00) begin
            s_nxt.tout = 1'b1;
         end else begin
            s_nxt.tmr = s_r.tmr - 8'h1;
         end
      end
      // Shared memory slave
      unique case (s_r.shm_st)
         SHM_IDLE: begin
            s_nxt.hp = 1'b0;
            if (s_r.shm[scr_pkg::SHM_ENABLE_BIT] && s_r.shm[scr_pkg::SHM_ROLE_BIT]
                && i_int_pending) begin
               s_nxt.shm_st = SHM_WAIT;
               s_nxt.shm_cnt = 8'h00;
            end
         end
         SHM_WAIT: begin
            if (i_high_prio) begin
               s_nxt.hp = 1'b1;
            end
            if (s_r.shm[7:0] != 8'h00 && s_r.shm_cnt + 8'h1 >= s_r.shm[7:0]) begin
               s_nxt.hp = 1'b1;
            end else begin
               s_nxt.shm_cnt = s_r.shm_cnt + 8'h1;
            end
            if (!i_grant_n) begin
               s_nxt.shm_st = SHM_OWN;
               s_nxt.shm_cnt = 8'h00;
            end
         end
         SHM_OWN: begin
            s_nxt.shm_cnt = s_r.shm_cnt + 8'h1;
            if ((s_r.shm[15:8] != 8'h00 && s_r.shm_cnt + 8'h1 >= s_r.shm[15:8])
                || (s_r.shm[15:8] == 8'h00 && !i_int_pending)) begin
               s_nxt.shm_st = SHM_GAP;
               s_nxt.gap = 2'd0;
            end
         end
         SHM_GAP: begin
            // Request stays high four cycles (three here, one in SHM_IDLE) before it may return
            s_nxt.gap = s_r.gap + 2'd1;
            if (s_r.gap == 2'd2) begin
               s_nxt.shm_st = SHM_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         s_r <= '0;
         s_r.timing <= scr_pkg::RST_TIMING;
         s_r.shm <= scr_pkg::RST_SHM_CNT;
         // Straps set role and enable so a slave can arbitrate before software runs
         s_r.shm[scr_pkg::SHM_ENABLE_BIT] <= i_shm_enable_strap;
         s_r.shm[scr_pkg::SHM_ROLE_BIT] <= i_shm_role_strap;
         s_r.xlo <= scr_pkg::RST_XBAR;
         s_r.xhi <= scr_pkg::RST_XBAR;
         s_r.xto <= scr_pkg::RST_TO;
         s_r.bank0 <= scr_pkg::RST_BANK;
         s_r.bank1 <= scr_pkg::RST_BANK;
         s_r.bank2 <= scr_pkg::RST_BANK;
         s_r.bank3 <= scr_pkg::RST_BANK;
         s_r.armed <= 1'b1;
         s_r.shm_st <= SHM_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // Outputs
   always_comb begin
      o_read_stages = 2'd2;
      if (!s_r.timing[scr_pkg::TIM_DEPTH_BIT] || ecc_on) begin
         o_read_stages = 2'd2;
      end else begin
         o_read_stages = 2'd1;
      end
      if (s_r.timing[scr_pkg::TIM_EXTRA_BIT]) begin
         o_read_stages = o_read_stages + 2'd1;
      end
   end
   assign o_rdata = s_r.rdata;
   assign o_rd_valid = s_r.ov;
   assign o_rd_data = s_r.od;
   assign o_irq = s_r.irq && !i_irq_mask;
   assign o_request_n = !(s_r.shm_st == SHM_WAIT || s_r.shm_st == SHM_OWN);
   assign o_high_prio_req = s_r.hp && s_r.shm_st == SHM_WAIT;
   assign o_xbar_owner = code_now;
   assign o_xbar_timeout = s_r.tout;
   assign o_density[0] = s_r.bank0[scr_pkg::BANK_DENS_LSB +: 2];
   assign o_density[1] = s_r.bank1[scr_pkg::BANK_DENS_LSB +: 2];
   assign o_density[2] = s_r.bank2[scr_pkg::BANK_DENS_LSB +: 2];
   assign o_density[3] = s_r.bank3[scr_pkg::BANK_DENS_LSB +: 2];
   assign o_keep_page[0] = s_r.bank0[scr_pkg::BANK_PAGE_LSB +: 4];
   assign o_keep_page[1] = s_r.bank1[scr_pkg::BANK_PAGE_LSB +: 4];
   assign o_keep_page[2] = s_r.bank2[scr_pkg::BANK_PAGE_LSB +: 4];
   assign o_keep_page[3] = s_r.bank3[scr_pkg::BANK_PAGE_LSB +: 4];

   // ==========================================================
   // Checks
   property p_ecc_depth;
      @(posedge i_clk) disable iff (!i_rstn)
      (ecc_on && !s_r.timing[scr_pkg::TIM_EXTRA_BIT]) |-> o_read_stages == 2'd2;
   endproperty
   a_ecc_depth: assert property (p_ecc_depth) else $error("ecc depth not two");
   property p_extra;
      @(posedge i_clk) disable iff (!i_rstn)
      s_r.timing[scr_pkg::TIM_EXTRA_BIT] |-> o_read_stages >= 2'd2;
   endproperty
   a_extra: assert property (p_extra) else $error("extra stage missing");
   property p_noecc;
      @(posedge i_clk) disable iff (!i_rstn)
      !ecc_on |-> syn == 8'h00;
   endproperty
   a_noecc: assert property (p_noecc) else $error("check active while off");
   property p_hold;
      @(posedge i_clk) disable iff (!i_rstn)
      (!s_r.armed && !i_rd) |=> $stable(s_r.edata);
   endproperty
   a_hold: assert property (p_hold) else $error("capture overwritten");
   property p_cnt;
      @(posedge i_clk) disable iff (!i_rstn)
      (i_rd_valid && single) |=> s_r.cnt == $past(s_r.cnt) + 32'h1;
   endproperty
   a_cnt: assert property (p_cnt) else $error("counter missed");
   property p_clear;
      @(posedge i_clk) disable iff (!i_rstn)
      (i_wr && i_addr == scr_pkg::OFF_ERR_ADDR && i_wdata[1:0] == 2'h0 && !i_rd_valid)
      |=> !s_r.irq;
   endproperty
   a_clear: assert property (p_clear) else $error("irq not cleared");
   property p_force;
      @(posedge i_clk) disable iff (!i_rstn)
      s_r.ctrl[scr_pkg::CTL_OVERRIDE_BIT] |-> o_wr_check == s_r.ctrl[7:0];
   endproperty
   a_force: assert property (p_force) else $error("override ignored");
   property p_thr0;
      @(posedge i_clk) disable iff (!i_rstn)
      (s_r.ctrl[23:16] == 8'h00 && !s_r.irq && !(i_rd_valid && multi) && !i_wr) |=> !s_r.irq;
   endproperty
   a_thr0: assert property (p_thr0) else $error("single error irq at zero");
   c_single: cover property (@(posedge i_clk) i_rd_valid && single);
   c_multi: cover property (@(posedge i_clk) i_rd_valid && multi);
   c_own: cover property (@(posedge i_clk) s_r.shm_st == SHM_OWN);
endmodule

//--- common/scr_pkg.sv
// Purpose: Constants for the SDRAM controller configuration and error-report registers
// Assumes: Plain register port, one core clock
// Notes: Offsets are byte addresses
package scr_pkg;
   localparam logic [11:0] OFF_BANK0 = 12'h44c;
   localparam logic [11:0] OFF_BANK1 = 12'h450;
   localparam logic [11:0] OFF_BANK2 = 12'h454;
   localparam logic [11:0] OFF_BANK3 = 12'h458;
   localparam logic [11:0] OFF_ERR_HI = 12'h480;
   localparam logic [11:0] OFF_ERR_LO = 12'h484;
   localparam logic [11:0] OFF_RX_ECC = 12'h488;
   localparam logic [11:0] OFF_CALC_ECC = 12'h48c;
   localparam logic [11:0] OFF_ERR_ADDR = 12'h490;
   localparam logic [11:0] OFF_ECC_CTRL = 12'h494;
   localparam logic [11:0] OFF_ECC_CNT = 12'h498;
   localparam logic [11:0] OFF_SHM_CTRL = 12'h4a4;
   localparam logic [11:0] OFF_XBAR_LO = 12'h4a8;
   localparam logic [11:0] OFF_XBAR_HI = 12'h4ac;
   localparam logic [11:0] OFF_XBAR_TO = 12'h4b0;
   localparam logic [11:0] OFF_TIMING = 12'h4b4;
   // Writable bit masks; all other bits are reserved and read zero
   localparam logic [31:0] MASK_BANK = 32'h000fc000;
   localparam logic [31:0] MASK_CTRL = 32'h00ff03ff;
   localparam logic [31:0] MASK_SHM = 32'h0003ffff;
   localparam logic [31:0] MASK_TO = 32'h000100ff;
   localparam logic [31:0] MASK_TIMING = 32'h00007f3f;
   // Field positions
   localparam int TIM_EXTRA_BIT = 12;
   localparam int TIM_ECC_BIT = 13;
   localparam int TIM_DEPTH_BIT = 14;
   localparam int SHM_ENABLE_BIT = 16;
   localparam int SHM_ROLE_BIT = 17;
   localparam int CTL_OVERRIDE_BIT = 8;
   localparam int CTL_PROP_BIT = 9;
   localparam int TO_DISABLE_BIT = 16;
   localparam int BANK_DENS_LSB = 14;
   localparam int BANK_PAGE_LSB = 16;
   // Reset values
   localparam logic [31:0] RST_BANK = 32'h0000c000;
   localparam logic [31:0] RST_TIMING = 32'h0000052a;
   localparam logic [31:0] RST_SHM_CNT = 32'h00000100;
   localparam logic [31:0] RST_XBAR = 32'h00765432;
   localparam logic [31:0] RST_TO = 32'h000100ff;
   // Error kinds and slice codes
   localparam logic [1:0] ERR_NONE = 2'h0;
   localparam logic [1:0] ERR_SINGLE = 2'h1;
   localparam logic [1:0] ERR_MULTI = 2'h2;
   localparam logic [3:0] SLICE_NULL = 4'h0;
   localparam logic [3:0] SLICE_CPU = 4'h2;
   localparam logic [3:0] SLICE_PCI = 4'h3;
   localparam logic [3:0] SLICE_COMM = 4'h5;
   localparam logic [3:0] SLICE_DMA = 4'h6;
   // Check-code matrix, one byte per data bit, data bit 63 first (bit 0 in the low byte)
   localparam logic [8*64-1:0] CODE_TABLE = {
      8'hc8, 8'hc4, 8'hc2, 8'hc1, 8'hf4, 8'h8f, 8'he0, 8'hb0,
      8'h0e, 8'h0b, 8'hf2, 8'h1f, 8'h86, 8'h46, 8'h26, 8'h16,
      8'h38, 8'h34, 8'h32, 8'h31, 8'ha8, 8'ha4, 8'ha2, 8'ha1,
      8'h98, 8'h94, 8'h92, 8'h91, 8'h58, 8'h54, 8'h52, 8'h51,
      8'h8a, 8'h4a, 8'h2a, 8'h1a, 8'h89, 8'h49, 8'h29, 8'h19,
      8'h85, 8'h45, 8'h25, 8'h15, 8'h8c, 8'h4c, 8'h2c, 8'h1c,
      8'h68, 8'h64, 8'h62, 8'h61, 8'hf8, 8'h4f, 8'h70, 8'hd0,
      8'h07, 8'h0d, 8'hf1, 8'h2f, 8'h83, 8'h43, 8'h23, 8'h13};
endpackage

//--- verification/scr_sdram_model.sv
// Purpose: Behavioural SDRAM word store for the check-code path
// Assumes: One stored word, kept with the check byte the block produced
// Notes: Idle lines toggle each cycle between the last beat and its inverse, so stale data never looks valid
`timescale 1ns/1ps
module scr_sdram_model (
   input wire logic i_clk, // Core clock
   input wire logic i_store, // Capture word and check byte
   input wire logic [63:0] i_data, // Word to store
   input wire logic [7:0] i_check, // Check byte from the block
   input wire logic i_fetch, // Return the stored word next cycle
   input wire logic [63:0] i_flip, // Data bits corrupted on fetch
   output logic o_valid, // Read beat valid
   output logic [63:0] o_data, // Read beat data
   output logic [7:0] o_check // Read beat check byte
);
   logic [63:0] mem_r;
   logic [7:0] chk_r;
   // ==========================================================
   // Store and return
   always_ff @(posedge i_clk) begin
      if (i_store) begin
         mem_r <= i_data;
         chk_r <= i_check;
      end
      o_valid <= i_fetch;
      o_data <= i_fetch ? (mem_r ^ i_flip) : ~o_data;
      o_check <= i_fetch ? chk_r : ~o_check;
   end
endmodule

//--- verification/tb.sv
// Purpose: Self-checking bench for the configuration and error-report block
// Assumes: 200 MHz clock, synchronous reset held 8 cycles
// Notes: The shared-bus agent is played by the bench through request and grant pins
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
   $display("Error t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb;
   logic i_clk, i_rstn, i_wr, i_rd, i_wr_parity_err, i_irq_mask, fetch, store;
   logic [11:0] i_addr;
   logic [31:0] i_wdata, i_rd_addr, o_rdata;
   logic [63:0] i_wr_data, flip, o_rd_data, m_data;
   logic [7:0] o_wr_check, m_check;
   logic o_rd_valid, m_valid, o_irq;
   logic [4:0] i_xbar_req;
   logic [3:0] o_xbar_owner;
   logic [1:0] o_density [4];
   logic [3:0] o_keep_page [4];
   logic [1:0] o_read_stages;
   logic i_int_pending, i_grant_n, o_request_n, o_high_prio_req, o_xbar_timeout;
   int err_count = 0;
   int cmp_count = 0;
   scr_regs scr_regs_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_shm_enable_strap(1'b1),
      .i_shm_role_strap(1'b0), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .i_wr_data(i_wr_data), .o_wr_check(o_wr_check),
      .i_wr_parity_err(i_wr_parity_err), .i_rd_valid(m_valid), .i_rd_data(m_data),
      .i_rd_check(m_check), .i_rd_addr(i_rd_addr), .o_rd_valid(o_rd_valid),
      .o_rd_data(o_rd_data), .i_irq_mask(i_irq_mask), .o_irq(o_irq),
      .i_int_pending(i_int_pending), .i_high_prio(1'b0), .i_grant_n(i_grant_n),
      .o_request_n(o_request_n), .o_high_prio_req(o_high_prio_req),
      .i_xbar_req(i_xbar_req), .o_xbar_owner(o_xbar_owner),
      .o_xbar_timeout(o_xbar_timeout), .o_density(o_density), .o_keep_page(o_keep_page),
      .o_read_stages(o_read_stages));
   scr_sdram_model scr_sdram_model_i (.i_clk(i_clk), .i_store(store), .i_data(i_wr_data),
      .i_check(o_wr_check), .i_fetch(fetch), .i_flip(flip), .o_valid(m_valid),
      .o_data(m_data), .o_check(m_check));
   // ==========================================================
   // Bus tasks; the extra edge after a write lets registered outputs settle
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
      @(posedge i_clk);
      #1;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 `CHK(o_rdata, e)
   endtask
   task automatic rd_beat(input logic [63:0] f, input logic [63:0] e);
      int n;
      @(posedge i_clk);
      fetch <= 1'b1;
      flip <= f;
      @(posedge i_clk);
      fetch <= 1'b0;
      for (n = 0; n < 8 && o_rd_valid !== 1'b1; n++) begin
         @(posedge i_clk);
         #1;
      end
      `CHK(o_rd_data, e)
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset;
      logic [11:0] a [12] = '{scr_pkg::OFF_TIMING, scr_pkg::OFF_SHM_CTRL, scr_pkg::OFF_XBAR_LO,
         scr_pkg::OFF_XBAR_HI, scr_pkg::OFF_XBAR_TO, scr_pkg::OFF_BANK0, scr_pkg::OFF_BANK3,
         scr_pkg::OFF_ERR_ADDR, scr_pkg::OFF_ECC_CTRL, scr_pkg::OFF_ECC_CNT,
         scr_pkg::OFF_ERR_LO, 12'h000};
      logic [31:0] v [12] = '{32'h052a, 32'h10100, 32'h765432, 32'h765432, 32'h100ff,
         32'hc000, 32'hc000, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
      for (int k = 0; k < 12; k++) rdc(a[k], v[k]);
   endtask
   task automatic t_fields;
      wr(scr_pkg::OFF_BANK1, 32'hffffffff);
      rdc(scr_pkg::OFF_BANK1, 32'h000fc000);
      `CHK(o_density[1], 2'h3)
      `CHK(o_keep_page[1], 4'hf)
      wr(scr_pkg::OFF_BANK1, 32'h00054000);
      `CHK(o_density[1], 2'h1)
      `CHK(o_keep_page[1], 4'h5)
      wr(scr_pkg::OFF_ECC_CNT, 32'h5);
      rdc(scr_pkg::OFF_ECC_CNT, 32'h0);
      wr(scr_pkg::OFF_XBAR_TO, 32'hffffffff);
      rdc(scr_pkg::OFF_XBAR_TO, 32'h000100ff);
   endtask
   task automatic t_stages;
      `CHK(o_read_stages, 2'd2)
      wr(scr_pkg::OFF_TIMING, 32'h1f2a);
      `CHK(o_read_stages, 2'd3)
      wr(scr_pkg::OFF_TIMING, 32'h4f2a);
      `CHK(o_read_stages, 2'd1)
      wr(scr_pkg::OFF_TIMING, 32'h6f2a);
      `CHK(o_read_stages, 2'd2)
   endtask
   task automatic t_check_byte;
      wr(scr_pkg::OFF_TIMING, 32'h2f2a);
      i_wr_data <= 64'h45;
      wr(scr_pkg::OFF_ECC_CTRL, 32'h155);
      `CHK(o_wr_check, 8'h55)
      i_wr_parity_err <= 1'b1;
      wr(scr_pkg::OFF_ECC_CTRL, 32'h200);
      `CHK(o_wr_check, 8'h5e)
      wr(scr_pkg::OFF_ECC_CTRL, 32'h10000);
      `CHK(o_wr_check, 8'h5d)
      i_wr_parity_err <= 1'b0;
   endtask
   // Word 0x45 stored with a good byte; flips give one, then two, data errors
   task automatic t_errors;
      @(posedge i_clk);
      store <= 1'b1;
      @(posedge i_clk);
      store <= 1'b0;
      rd_beat(64'h4, 64'h45);
      rdc(scr_pkg::OFF_ERR_LO, 32'h41);
      rdc(scr_pkg::OFF_ERR_HI, 32'h0);
      rdc(scr_pkg::OFF_RX_ECC, 32'h5d);
      rdc(scr_pkg::OFF_CALC_ECC, 32'h1e);
      rdc(scr_pkg::OFF_ECC_CNT, 32'h1);
      `CHK(o_irq, 1'b1)
      rd_beat(64'h3, 64'h46);
      rdc(scr_pkg::OFF_ERR_LO, 32'h41);
      rdc(scr_pkg::OFF_ERR_ADDR, 32'h12345679);
      rd_beat(64'h3, 64'h46);
      rdc(scr_pkg::OFF_ERR_ADDR, 32'h1234567a);
      rdc(scr_pkg::OFF_ECC_CNT, 32'h1);
      i_irq_mask <= 1'b1;
      @(posedge i_clk);
      #1 `CHK(o_irq, 1'b0)
      i_irq_mask <= 1'b0;
      wr(scr_pkg::OFF_ERR_ADDR, 32'h0);
      `CHK(o_irq, 1'b0)
   endtask
   // Escalation after 3 cycles, release 2 cycles after the grant
   task automatic t_shared;
      wr(scr_pkg::OFF_SHM_CTRL, 32'h00030203);
      i_int_pending <= 1'b1;
      repeat (2) @(posedge i_clk);
      #1 `CHK(o_request_n, 1'b0)
      `CHK(o_high_prio_req, 1'b0)
      repeat (3) @(posedge i_clk);
      #1 `CHK(o_high_prio_req, 1'b1)
      i_grant_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      #1 `CHK(o_request_n, 1'b0)
      @(posedge i_clk);
      #1 `CHK(o_request_n, 1'b1)
      i_grant_n <= 1'b1;
      i_int_pending <= 1'b0;
   endtask
   // Only the PCI slice is requested: the ring walks to slice 9 and parks there
   task automatic t_xbar;
      int n;
      i_xbar_req <= 5'h02;
      wr(scr_pkg::OFF_XBAR_LO, 32'h0);
      wr(scr_pkg::OFF_XBAR_HI, 32'h00000030);
      repeat (20) @(posedge i_clk);
      #1 `CHK(o_xbar_owner, 4'h3)
      `CHK(o_xbar_timeout, 1'b0)
      wr(scr_pkg::OFF_XBAR_TO, 32'h00000003);
      for (n = 0; n < 400 && o_xbar_timeout !== 1'b1; n++) begin
         @(posedge i_clk);
         #1;
      end
      `CHK(o_xbar_timeout, 1'b1)
      `CHK(o_xbar_owner, 4'h3)
      @(posedge i_clk);
      #1 `CHK(o_xbar_owner, 4'h0)
   endtask
   task automatic wrap_up;
      if (err_count == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ==========================================================
   // Clock, sequence and watchdog
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   initial begin
      {i_rstn, i_wr, i_rd, i_wr_parity_err, i_irq_mask, fetch, store, i_int_pending} = '0;
      i_grant_n = 1'b1;
      i_addr = '0;
      i_wdata = '0;
      i_wr_data = '0;
      flip = '0;
      i_rd_addr = 32'h12345678;
      i_xbar_req = 5'h1f;
      repeat (8) @(posedge i_clk);
      i_rstn <= 1'b1;
      t_reset();
      t_fields();
      t_stages();
      t_check_byte();
      t_errors();
      t_shared();
      t_xbar();
      wrap_up();
   end
   initial begin
      repeat (5000) @(posedge i_clk);
      err_count++;
      wrap_up();
   end
endmodule
